//--- cpu_special_regs_defs.svh
// Constants for the core register set: register count, register numbers, field codes.
// Assumes inclusion by bare name from design files only.
`ifndef CPU_SPECIAL_REGS_DEFS_SVH
`define CPU_SPECIAL_REGS_DEFS_SVH
`define GPR_COUNT 32'h20
`define GPR_ZERO 5'h00
`define GPR_SAVED_FIRST 5'h10
`define GPR_SAVED_SECOND 5'h11
`define GPR_GLOBAL_POINTER 5'h1c
`define GPR_STACK_POINTER 5'h1d
`define GPR_RETURN_ADDRESS 5'h1f
`define CREG_ZERO_CODE 3'h0
`define CREG_ONE_CODE 3'h1
`define ACC_DEFAULT 2'h0
`define PC_RESET 32'h00000000
`define WORD_ZERO 32'h00000000
`define PAIR_ZERO 64'h0000000000000000
`endif

//--- cpu_special_regs_pkg.sv
// Types shared by the core register set.
// Assumes the defs header is available for constants.
package cpu_special_regs_pkg;
	typedef enum logic [2:0] {
		acc_none,
		acc_mult,
		acc_madd,
		acc_msub,
		acc_div,
		acc_mac
	} acc_op_t;
	typedef enum logic [1:0] {
		imp_none,
		imp_global,
		imp_stack,
		imp_return
	} implicit_sel_t;
endpackage

//--- cpu_special_register_set.sv
// General-purpose registers, program counter and four accumulator pairs.
// Assumes the execution pipeline supplies computed products, quotients and remainders.
`timescale 1ns/10ps
`include "cpu_special_regs_defs.svh"

module cpu_special_register_set #(
	parameter int XLEN = 32,
	parameter int NUM_ACC = 4
) (
	input wire logic i_clk, // Core clock
	input wire logic i_rst, // Synchronous reset, high
	input wire logic i_ce, // Clock enable
	input wire logic [4:0] i_rd_addr_a, // Read port A register number
	input wire logic [4:0] i_rd_addr_b, // Read port B register number
	input wire logic i_rd_pc_a, // Port A returns PC instead
	output logic [XLEN-1:0] o_rd_data_a, // Port A data, registered
	output logic [XLEN-1:0] o_rd_data_b, // Port B data, registered
	input wire logic i_wr_en, // GPR write strobe
	input wire logic [4:0] i_wr_addr, // GPR write register number
	input wire logic [XLEN-1:0] i_wr_data, // GPR write data
	input wire logic [2:0] i_creg_code, // Compressed register field
	input wire logic i_creg_alt_zero, // Code 0 means register 0
	input wire cpu_special_regs_pkg::implicit_sel_t i_imp_sel, // Implicit register use
	output logic [4:0] o_creg_num, // Decoded register number
	input wire logic i_pc_load, // Load new PC
	input wire logic [XLEN-1:0] i_pc_next, // Next PC value
	output logic [XLEN-1:0] o_pc, // Current PC
	input wire cpu_special_regs_pkg::acc_op_t i_acc_op, // Accumulator operation
	input wire logic i_acc_sel_en, // Use explicit pair field
	input wire logic [1:0] i_acc_sel, // Explicit pair field
	input wire logic [2*XLEN-1:0] i_product, // Full multiply product
	input wire logic [XLEN-1:0] i_quotient, // Divide quotient
	input wire logic [XLEN-1:0] i_remainder, // Divide remainder
	input wire logic [1:0] i_acc_rd_sel, // Pair to read out
	output logic [XLEN-1:0] o_accum_high_word, // Read pair high word
	output logic [XLEN-1:0] o_accum_low_word // Read pair low word
);
	logic [XLEN-1:0] gpr [0:`GPR_COUNT-1];
	logic [XLEN-1:0] accum_high_word [0:NUM_ACC-1];
	logic [XLEN-1:0] accum_low_word [0:NUM_ACC-1];
	// Internal copy so the operand mux never reads an output port
	logic [XLEN-1:0] pc;

	// Pair zero unless the instruction names one
	wire logic [1:0] acc_idx = i_acc_sel_en ? i_acc_sel : `ACC_DEFAULT;
	wire logic [2*XLEN-1:0] acc_cur = {accum_high_word[acc_idx], accum_low_word[acc_idx]};
	wire logic [2*XLEN-1:0] acc_sum = acc_cur + i_product;
	wire logic [2*XLEN-1:0] acc_diff = acc_cur - i_product;
	wire logic [2*XLEN-1:0] next_pair =
		(i_acc_op == cpu_special_regs_pkg::acc_mult) ? i_product :
		(i_acc_op == cpu_special_regs_pkg::acc_msub) ? acc_diff :
		(i_acc_op == cpu_special_regs_pkg::acc_div) ? {i_remainder, i_quotient} :
		acc_sum;
	wire logic acc_we = (i_acc_op != cpu_special_regs_pkg::acc_none);

	function automatic logic [4:0] creg_map(input logic [2:0] code, input logic alt_zero);
		logic [4:0] r;
		r = {2'h0, code};
		if (code == `CREG_ZERO_CODE) begin
			r = alt_zero ? `GPR_ZERO : `GPR_SAVED_FIRST;
		end else if (code == `CREG_ONE_CODE) begin
			r = `GPR_SAVED_SECOND;
		end
		return r;
	endfunction

	// Implicit uses override the field since these registers have no code
	wire logic [4:0] next_creg_num =
		(i_imp_sel == cpu_special_regs_pkg::imp_global) ? `GPR_GLOBAL_POINTER :
		(i_imp_sel == cpu_special_regs_pkg::imp_stack) ? `GPR_STACK_POINTER :
		(i_imp_sel == cpu_special_regs_pkg::imp_return) ? `GPR_RETURN_ADDRESS :
		creg_map(i_creg_code, i_creg_alt_zero);

	function automatic logic [XLEN-1:0] gpr_read(input logic [4:0] a, input logic [XLEN-1:0] v);
		return (a == `GPR_ZERO) ? `WORD_ZERO : v;
	endfunction

	// Write-through so a read in the write cycle sees the new value
	function automatic logic [XLEN-1:0] fwd_pick(input logic [4:0] a, input logic [XLEN-1:0] v,
		input logic we, input logic [4:0] wa, input logic [XLEN-1:0] wd);
		return (we && wa == a) ? wd : v;
	endfunction
	wire logic [XLEN-1:0] fwd_a = fwd_pick(i_rd_addr_a, gpr[i_rd_addr_a],
		i_wr_en, i_wr_addr, i_wr_data);
	wire logic [XLEN-1:0] fwd_b = fwd_pick(i_rd_addr_b, gpr[i_rd_addr_b],
		i_wr_en, i_wr_addr, i_wr_data);
	wire logic [XLEN-1:0] next_rd_a = i_rd_pc_a ? pc : gpr_read(i_rd_addr_a, fwd_a);
	wire logic [XLEN-1:0] next_rd_b = gpr_read(i_rd_addr_b, fwd_b);
	// No stack pointer logic here; software owns the stack

	// Slot zero is never written, so it keeps its reset zero
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int i = 0; i < `GPR_COUNT; i++) begin
				gpr[i] <= `WORD_ZERO;
			end
		end else if (i_ce && i_wr_en && i_wr_addr != `GPR_ZERO) begin
			gpr[i_wr_addr] <= i_wr_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int i = 0; i < NUM_ACC; i++) begin
				accum_high_word[i] <= `WORD_ZERO;
				accum_low_word[i] <= `WORD_ZERO;
			end
		end else if (i_ce && acc_we) begin
			accum_high_word[acc_idx] <= next_pair[2*XLEN-1:XLEN];
			accum_low_word[acc_idx] <= next_pair[XLEN-1:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pc <= `PC_RESET;
			o_pc <= `PC_RESET;
			o_rd_data_a <= `WORD_ZERO;
			o_rd_data_b <= `WORD_ZERO;
			o_creg_num <= `GPR_ZERO;
			o_accum_high_word <= `WORD_ZERO;
			o_accum_low_word <= `WORD_ZERO;
		end else if (i_ce) begin
			if (i_pc_load) begin
				pc <= i_pc_next;
				o_pc <= i_pc_next;
			end
			o_rd_data_a <= next_rd_a;
			o_rd_data_b <= next_rd_b;
			o_creg_num <= next_creg_num;
			// Same-cycle op not yet visible; readout lags the write by one
			o_accum_high_word <= accum_high_word[i_acc_rd_sel];
			o_accum_low_word <= accum_low_word[i_acc_rd_sel];
		end
	end

	// Checks look one clock edge behind the inputs they sample (two edges for the multiply and divide placement checks), whether or not that edge is enabled
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence mult_issue_s;
		i_ce && i_acc_op == cpu_special_regs_pkg::acc_mult && !i_acc_sel_en;
	endsequence
	sequence read_pair0_s;
		i_ce && i_acc_rd_sel == `ACC_DEFAULT && i_acc_op == cpu_special_regs_pkg::acc_none;
	endsequence

	mult_pair_zero_a: assert property (mult_issue_s ##1 read_pair0_s |=>
		{o_accum_high_word, o_accum_low_word} == $past(i_product, 2))
		else $error("multiply product not in pair zero");
	div_placement_a: assert property (i_ce && i_acc_op == cpu_special_regs_pkg::acc_div
		&& !i_acc_sel_en ##1 read_pair0_s |=> o_accum_low_word == $past(i_quotient, 2)
		&& o_accum_high_word == $past(i_remainder, 2))
		else $error("divide result placement wrong");
	madd_sum_a: assert property (i_ce && i_acc_op == cpu_special_regs_pkg::acc_madd
		|=> {accum_high_word[$past(acc_idx)], accum_low_word[$past(acc_idx)]}
		== $past(acc_cur) + $past(i_product))
		else $error("multiply-add sum wrong");
	msub_diff_a: assert property (i_ce && i_acc_op == cpu_special_regs_pkg::acc_msub
		|=> {accum_high_word[$past(acc_idx)], accum_low_word[$past(acc_idx)]}
		== $past(acc_cur) - $past(i_product))
		else $error("multiply-subtract difference wrong");
	mac_running_a: assert property (i_ce && i_acc_op == cpu_special_regs_pkg::acc_mac
		|=> {accum_high_word[$past(acc_idx)], accum_low_word[$past(acc_idx)]}
		== $past(acc_cur) + $past(i_product))
		else $error("accumulate result wrong");
	acc_select_a: assert property (i_ce && acc_we && i_acc_sel_en
		|=> accum_low_word[$past(i_acc_sel)] == $past(next_pair[XLEN-1:0]))
		else $error("accumulator field ignored");
	creg_zero_a: assert property (i_ce && i_imp_sel == cpu_special_regs_pkg::imp_none
		&& i_creg_code == `CREG_ZERO_CODE
		|=> o_creg_num == ($past(i_creg_alt_zero) ? `GPR_ZERO : `GPR_SAVED_FIRST))
		else $error("code zero decode wrong");
	creg_high_a: assert property (i_ce && i_imp_sel == cpu_special_regs_pkg::imp_none
		&& i_creg_code > `CREG_ONE_CODE |=> o_creg_num == {2'h0, $past(i_creg_code)})
		else $error("code two to seven decode wrong");
	implicit_stack_a: assert property (i_ce && i_imp_sel == cpu_special_regs_pkg::imp_stack
		|=> o_creg_num == `GPR_STACK_POINTER)
		else $error("implicit stack register wrong");
	pc_operand_a: assert property (i_ce && i_rd_pc_a && !i_pc_load
		|=> o_rd_data_a == o_pc)
		else $error("pc operand mismatch");
	zero_reads_a: assert property (i_ce && !i_rd_pc_a && i_rd_addr_a == `GPR_ZERO
		|=> o_rd_data_a == `WORD_ZERO)
		else $error("register zero not zero");
	rd_b_zero_a: assert property (i_ce && i_rd_addr_b == `GPR_ZERO
		|=> o_rd_data_b == `WORD_ZERO)
		else $error("port b register zero not zero");
	zero_write_a: assert property (i_ce && i_wr_en && i_wr_addr == `GPR_ZERO
		|=> $stable(gpr[`GPR_ZERO]))
		else $error("register zero was written");
	creg_one_a: assert property (i_ce && i_imp_sel == cpu_special_regs_pkg::imp_none
		&& i_creg_code == `CREG_ONE_CODE |=> o_creg_num == `GPR_SAVED_SECOND)
		else $error("code one decode wrong");
	implicit_global_a: assert property (i_ce
		&& i_imp_sel == cpu_special_regs_pkg::imp_global
		|=> o_creg_num == `GPR_GLOBAL_POINTER)
		else $error("implicit global register wrong");
	implicit_return_a: assert property (i_ce
		&& i_imp_sel == cpu_special_regs_pkg::imp_return
		|=> o_creg_num == `GPR_RETURN_ADDRESS)
		else $error("implicit return register wrong");
	pc_load_a: assert property (i_ce && i_pc_load |=> o_pc == $past(i_pc_next))
		else $error("program counter load wrong");

	// Low enable must hold every output, so a stalled pipe sees no drift
	sequence hold_cycle_s;
		!i_ce;
	endsequence
	frozen_outputs_a: assert property (hold_cycle_s |=> $stable(o_rd_data_a)
		&& $stable(o_rd_data_b) && $stable(o_pc) && $stable(o_creg_num)
		&& $stable(o_accum_high_word) && $stable(o_accum_low_word))
		else $error("outputs moved while enable low");

	sequence other_pair_write_s;
		i_ce && acc_we && i_acc_sel_en && i_acc_sel != `ACC_DEFAULT;
	endsequence
	other_pair_a: assert property (other_pair_write_s |=>
		$stable(accum_high_word[`ACC_DEFAULT]) && $stable(accum_low_word[`ACC_DEFAULT]))
		else $error("pair zero changed by explicit op");
endmodule

//--- cpu_pipe_model.sv
// Pipeline stand-in: forms the full product for the register set.
// Assumes operands are held steady for the cycle the op is taken.
`timescale 1ns/10ps
module cpu_pipe_model (
	input wire logic [31:0] i_mul_a, // First operand
	input wire logic [31:0] i_mul_b, // Second operand
	output logic [63:0] o_product // Full unsigned product
);
	// Products only; no stack kept, software owns it
	assign o_product = {32'h00000000, i_mul_a} * {32'h00000000, i_mul_b};
endmodule

//--- cpu_special_register_set_tb_top.sv
// Bench for the core register set; drives the pipeline side at falling edges.
// Assumes the design, its package and the pipeline model are compiled first.
`timescale 1ns/10ps
module cpu_special_register_set_tb_top;
	logic clk = 0, rst = 1, ce = 1, pca = 0, we = 0, alt = 0, en = 0, pcl = 0;
	logic [4:0] addr_a = 0, rb = 0, wa = 0, cn;
	logic [31:0] wd = 0, pcn = 0, ma = 0, mb = 0, rda, rdb, pc, hw, lw;
	logic [2:0] code = 0;
	logic [1:0] sel = 0, rsel = 0;
	logic [63:0] prod;
	cpu_special_regs_pkg::implicit_sel_t imp = cpu_special_regs_pkg::imp_none;
	cpu_special_regs_pkg::acc_op_t aop = cpu_special_regs_pkg::acc_none;
	int errors = 0, checks_done = 0;
	always #20 clk = ~clk;
	cpu_pipe_model cpu_pipe_model_i (.i_mul_a(ma), .i_mul_b(mb), .o_product(prod));
	cpu_special_register_set cpu_special_register_set_i (.i_clk(clk), .i_rst(rst),
		.i_ce(ce), .i_rd_addr_a(addr_a), .i_rd_addr_b(rb), .i_rd_pc_a(pca),
		.o_rd_data_a(rda), .o_rd_data_b(rdb), .i_wr_en(we), .i_wr_addr(wa),
		.i_wr_data(wd), .i_creg_code(code), .i_creg_alt_zero(alt), .i_imp_sel(imp),
		.o_creg_num(cn), .i_pc_load(pcl), .i_pc_next(pcn), .o_pc(pc), .i_acc_op(aop),
		.i_acc_sel_en(en), .i_acc_sel(sel), .i_product(prod), .i_quotient(ma),
		.i_remainder(mb), .i_acc_rd_sel(rsel), .o_accum_high_word(hw),
		.o_accum_low_word(lw));
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task wrap_up;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Chained ops land back to back; caller reads afterwards
	task acc(input cpu_special_regs_pkg::acc_op_t op, input logic e, input logic [1:0] s,
		input logic [31:0] a, input logic [31:0] b);
		@(negedge clk);
		aop = op;
		en = e;
		sel = s;
		ma = a;
		mb = b;
	endtask
	task rd(input logic [1:0] p, input logic [63:0] exp);
		@(negedge clk);
		aop = cpu_special_regs_pkg::acc_none;
		rsel = p;
		@(negedge clk);
		chk({hw, lw}, exp);
	endtask
	task t_gpr;
		@(negedge clk);
		we = 1;
		wa = 5'h05;
		wd = 32'h1234abcd;
		@(negedge clk);
		wa = 5'h00;
		wd = 32'hffffffff;
		@(negedge clk);
		we = 0;
		addr_a = 5'h05;
		rb = 5'h00;
		@(negedge clk);
		chk(rda, 64'h1234abcd);
		chk(rdb, 64'h0);
	endtask
	task t_pc;
		@(negedge clk);
		pcl = 1;
		pcn = 32'h00000400;
		@(negedge clk);
		pcl = 0;
		pca = 1;
		chk(pc, 64'h400);
		@(negedge clk);
		chk(rda, 64'h400);
		pca = 0;
	endtask
	task t_creg;
		for (int c = 0; c < 9; c++) begin
			@(negedge clk);
			code = c[2:0];
			alt = (c == 8);
			@(negedge clk);
			chk(cn, c == 8 ? 0 : c == 0 ? 16 : c == 1 ? 17 : c);
		end
		for (int i = 1; i < 4; i++) begin
			@(negedge clk);
			imp = cpu_special_regs_pkg::implicit_sel_t'(i);
			@(negedge clk);
			chk(cn, i == 1 ? 28 : i == 2 ? 29 : 31);
		end
		imp = cpu_special_regs_pkg::imp_none;
	endtask
	task t_acc;
		rd(2'h0, 64'h0);
		acc(cpu_special_regs_pkg::acc_mult, 0, 2'h3, 32'hffffffff, 32'h2);
		rd(2'h0, 64'h1fffffffe);
		acc(cpu_special_regs_pkg::acc_madd, 0, 2'h3, 32'h1, 32'h2);
		acc(cpu_special_regs_pkg::acc_msub, 0, 2'h0, 32'h3, 32'h1);
		rd(2'h0, 64'h1fffffffd);
		acc(cpu_special_regs_pkg::acc_mult, 1, 2'h3, 32'h10000, 32'h10000);
		acc(cpu_special_regs_pkg::acc_mac, 1, 2'h3, 32'h2, 32'h3);
		acc(cpu_special_regs_pkg::acc_div, 1, 2'h1, 32'h5, 32'h7);
		rd(2'h3, 64'h100000006);
		rd(2'h1, 64'h700000005);
		rd(2'h0, 64'h1fffffffd);
	endtask
	// Write-through on a same-cycle read, then a frozen cycle that must drop all work
	task t_hold;
		@(negedge clk);
		we = 1;
		wa = 5'h06;
		wd = 32'h0badf00d;
		addr_a = 5'h06;
		@(negedge clk);
		chk(rda, 64'h0badf00d);
		ce = 0;
		wd = 32'h11111111;
		addr_a = 5'h05;
		aop = cpu_special_regs_pkg::acc_mult;
		ma = 32'h3;
		mb = 32'h3;
		@(negedge clk);
		chk(rda, 64'h0badf00d);
		ce = 1;
		we = 0;
		aop = cpu_special_regs_pkg::acc_none;
		addr_a = 5'h06;
		@(negedge clk);
		chk(rda, 64'h0badf00d);
		chk({hw, lw}, 64'h0);
	endtask
	// Mid-run reset clears pairs, registers and outputs in one edge
	task t_rst;
		@(negedge clk);
		rst = 1;
		@(negedge clk);
		chk({hw, lw}, 64'h0);
		chk(pc, 64'h0);
		rst = 0;
		rsel = 2'h3;
		addr_a = 5'h05;
		@(negedge clk);
		chk({hw, lw}, 64'h0);
		chk(rda, 64'h0);
	endtask
	initial begin
		repeat (10) @(negedge clk);
		rst = 0;
		t_gpr();
		t_hold();
		t_pc();
		t_creg();
		t_acc();
		t_rst();
		wrap_up();
	end
	initial begin
		#100us;
		errors++;
		wrap_up();
	end
endmodule
